// file: pkg/fhf_pkg.sv
// constants and types for the fill-level flag queue
// ==========================================
// How it works
// - each handshake flag can be disabled, polarity chosen at build time
// - write acknowledge pulses one cycle after each accepted write
// - standard mode: read-valid for each accepted read, low for empty reads
// - standard mode: data and read-valid appear the cycle after the request
// - look-ahead mode: head word shown unrequested, read-valid while any word held
// - write while full: no acknowledge, overflow raised, queue unchanged
// - read while empty: no read-valid, underflow raised, queue unchanged
// - high flag sets when count reaches set threshold; writes go on until full
// - high flag clears when count drops below the clear threshold
// - high flag sets on the edge after the write reaching the threshold
// - hard-primitive single threshold clears only below threshold minus one
// - five threshold schemes selectable for the high flag; low flag single or pair constant only; hard primitive only single constant
// - word count output and high flag lag the write by one cycle
// - low flag sets at count <= set level, clears above clear level
// - a write stores the word when enabled and the queue is not full
// ==========================================
`default_nettype none
package fhf_pkg;
	localparam int FHF_DW = 8;
	localparam int FHF_DEPTH = 8;
	localparam int FHF_AW = 3;
	localparam int FHF_CW = 4;
	localparam logic [FHF_CW-1:0] FHF_CNT_RST = 4'h0;
	localparam logic [FHF_CW-1:0] FHF_HI_SET_CONST = 4'h6;
	localparam logic [FHF_CW-1:0] FHF_HI_CLR_CONST = 4'h4;
	localparam logic [FHF_CW-1:0] FHF_LO_SET_CONST = 4'h1;
	localparam logic [FHF_CW-1:0] FHF_LO_CLR_CONST = 4'h2;
	localparam logic FHF_HI_RST = 1'b0;
	localparam logic FHF_LO_RST = 1'b1;
	typedef enum logic [2:0] {
		FHF_TH_SINGLE_CONST,
		FHF_TH_SINGLE_PORT,
		FHF_TH_PAIR_CONST,
		FHF_TH_PAIR_PORT,
		FHF_TH_HARD_CONST
	} fhf_thresh_mode_t;
endpackage
`default_nettype wire

// file: rtl/fhf_fifo.sv
// storage queue with valid/ready on both sides and read data taken combinationally from the head entry
`default_nettype none
module fhf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [AW:0] count
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wptr_r;
	logic [AW-1:0] rptr_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	// ==========================================
	// handshake decode
	// a pop in the same cycle does not make room for a push
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push = in_valid && (cnt_r != (AW+1)'(DEPTH));
	assign pop = out_ready && out_valid;
	assign count = cnt_r;
	assign out_data = mem_r[rptr_r];
	// ==========================================
	// pointers and storage
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wptr_r <= wptr_r + 1'b1;
			if (pop)
				rptr_r <= rptr_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge clk_sys) begin
		if (push)
			mem_r[wptr_r] <= in_data;
	end
endmodule
`default_nettype wire

// file: rtl/fhf_top.sv
// handshake and fill-level flags around an 8-word queue
`default_nettype none
module fhf_top import fhf_pkg::*; #(
	parameter bit WR_ACK_EN = 1'b1,
	parameter bit WR_ACK_HIGH = 1'b1,
	parameter bit RD_VALID_EN = 1'b1,
	parameter bit RD_VALID_HIGH = 1'b1,
	parameter bit OVERFLOW_EN = 1'b1,
	parameter bit OVERFLOW_HIGH = 1'b1,
	parameter bit UNDERFLOW_EN = 1'b1,
	parameter bit UNDERFLOW_HIGH = 1'b1,
	parameter bit LOOK_AHEAD = 1'b0,
	parameter fhf_thresh_mode_t HI_MODE = FHF_TH_PAIR_PORT,
	parameter fhf_thresh_mode_t LO_MODE = FHF_TH_PAIR_CONST
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [FHF_DW-1:0] wr_data,
	input wire logic rd_en,
	output logic [FHF_DW-1:0] rd_data,
	output logic full,
	output logic empty,
	output logic wr_ack,
	output logic rd_valid,
	output logic overflow,
	output logic underflow,
	output logic [FHF_CW-1:0] wr_count,
	output logic fill_level_high_flag,
	output logic fill_level_low_flag,
	input wire logic [FHF_CW-1:0] high_level_threshold_in,
	input wire logic [FHF_CW-1:0] high_level_set_threshold_in,
	input wire logic [FHF_CW-1:0] high_level_clear_threshold_in
);
	logic q_in_ready;
	logic q_out_valid;
	logic [FHF_DW-1:0] q_out_data;
	logic [FHF_CW-1:0] q_count;
	logic wr_ok;
	logic wr_bad;
	logic rd_ok;
	logic rd_bad;
	logic q_pop;
	logic [FHF_CW-1:0] cnt_after;
	logic [FHF_CW-1:0] hi_set;
	logic [FHF_CW-1:0] hi_clr;
	logic hi_nxt;
	logic lo_nxt;
	logic [FHF_CW-1:0] th_single_r;
	logic [FHF_CW-1:0] th_set_r;
	logic [FHF_CW-1:0] th_clr_r;
	logic wr_ack_r;
	logic rd_valid_r;
	logic overflow_r;
	logic underflow_r;
	logic hi_r;
	logic lo_r;
	logic full_r;
	logic empty_r;
	logic [FHF_CW-1:0] wr_count_r;
	logic [FHF_DW-1:0] rd_data_r;

	// ==========================================
	// queue
	fhf_fifo #(
		.WIDTH(FHF_DW),
		.DEPTH(FHF_DEPTH),
		.AW(FHF_AW)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_valid(wr_ok),
		.in_ready(q_in_ready),
		.in_data(wr_data),
		.out_valid(q_out_valid),
		.out_ready(q_pop),
		.out_data(q_out_data),
		.count(q_count)
	);

	// ==========================================
	// request decode
	// a write is taken only when not full; same-cycle read does not make room
	assign wr_ok = wr_en && q_in_ready;
	assign wr_bad = wr_en && !wr_ok;
	assign rd_ok = rd_en && q_out_valid;
	assign rd_bad = rd_en && !q_out_valid;
	assign q_pop = rd_ok;
	assign cnt_after = q_count + FHF_CW'(wr_ok) - FHF_CW'(rd_ok);

	// ==========================================
	// threshold selection, ports captured while in reset
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			th_single_r <= high_level_threshold_in;
			th_set_r <= high_level_set_threshold_in;
			th_clr_r <= high_level_clear_threshold_in;
		end
	end
	assign hi_set = (HI_MODE == FHF_TH_SINGLE_PORT) ? th_single_r :
		(HI_MODE == FHF_TH_PAIR_PORT) ? th_set_r : FHF_HI_SET_CONST;
	assign hi_clr = (HI_MODE == FHF_TH_SINGLE_PORT) ? th_single_r :
		(HI_MODE == FHF_TH_PAIR_PORT) ? th_clr_r :
		(HI_MODE == FHF_TH_PAIR_CONST) ? FHF_HI_CLR_CONST :
		(HI_MODE == FHF_TH_HARD_CONST) ? FHF_HI_SET_CONST - 4'h1 : FHF_HI_SET_CONST;
	// hysteresis: set at or above, clear below, otherwise hold
	assign hi_nxt = (cnt_after >= hi_set) ? 1'b1 : (cnt_after < hi_clr) ? 1'b0 : hi_r;
	assign lo_nxt = (cnt_after <= FHF_LO_SET_CONST) ? 1'b1 :
		(cnt_after > ((LO_MODE == FHF_TH_PAIR_CONST) ? FHF_LO_CLR_CONST : FHF_LO_SET_CONST)) ? 1'b0 : lo_r;

	// ==========================================
	// flag registers
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wr_ack_r <= 1'b0;
			overflow_r <= 1'b0;
			rd_valid_r <= 1'b0;
			underflow_r <= 1'b0;
			hi_r <= FHF_HI_RST;
			lo_r <= FHF_LO_RST;
			full_r <= 1'b0;
			empty_r <= 1'b1;
			wr_count_r <= FHF_CNT_RST;
			rd_data_r <= '0;
		end else begin
			wr_ack_r <= wr_ok;
			overflow_r <= wr_bad;
			underflow_r <= rd_bad;
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
			full_r <= (cnt_after == FHF_CW'(FHF_DEPTH));
			empty_r <= (cnt_after == '0);
			wr_count_r <= cnt_after;
			if (LOOK_AHEAD) begin
				// head word after this edge, shown without request
				rd_valid_r <= (cnt_after != '0);
				if (rd_ok)
					rd_data_r <= (q_count > 4'h1) ? u_fifo.mem_r[u_fifo.rptr_r + 3'h1] :
						(wr_ok ? wr_data : rd_data_r);
				else if (q_count == '0 && wr_ok)
					rd_data_r <= wr_data;
				else if (q_out_valid)
					rd_data_r <= q_out_data;
			end else begin
				rd_valid_r <= rd_ok;
				if (rd_ok)
					rd_data_r <= q_out_data;
			end
		end
	end

	// ==========================================
	// polarity and enable of handshake outputs
	assign wr_ack = WR_ACK_EN ? (wr_ack_r ~^ WR_ACK_HIGH) : !WR_ACK_HIGH;
	assign rd_valid = RD_VALID_EN ? (rd_valid_r ~^ RD_VALID_HIGH) : !RD_VALID_HIGH;
	assign overflow = OVERFLOW_EN ? (overflow_r ~^ OVERFLOW_HIGH) : !OVERFLOW_HIGH;
	assign underflow = UNDERFLOW_EN ? (underflow_r ~^ UNDERFLOW_HIGH) : !UNDERFLOW_HIGH;
	assign fill_level_high_flag = hi_r;
	assign fill_level_low_flag = lo_r;
	assign full = full_r;
	assign empty = empty_r;
	assign wr_count = wr_count_r;
	assign rd_data = rd_data_r;
endmodule
`default_nettype wire

// file: tb/fhf_props.sv
// checker for the flag queue ports
`default_nettype none
module fhf_props import fhf_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic full,
	input wire logic empty,
	input wire logic wr_ack,
	input wire logic rd_valid,
	input wire logic overflow,
	input wire logic underflow,
	input wire logic [7:0] rd_data,
	input wire logic [3:0] wr_count,
	input wire logic fill_level_high_flag,
	input wire logic [3:0] high_level_set_threshold_in,
	input wire logic [3:0] high_level_clear_threshold_in
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_ack; wr_en && !full |=> wr_ack && !overflow; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ovf; wr_en && full |=> overflow && !wr_ack; endproperty
	a_ovf: assert property (p_ovf) else $error("no overflow");
	property p_keep; wr_en && full && !rd_en |=> full && $stable(wr_count); endproperty
	a_keep: assert property (p_keep) else $error("full moved");
	property p_rdv; rd_en && !empty |=> rd_valid && !underflow; endproperty
	a_rdv: assert property (p_rdv) else $error("no valid");
	property p_udf; rd_en && empty |=> underflow && !rd_valid && $stable(rd_data); endproperty
	a_udf: assert property (p_udf) else $error("no underflow");
	property p_cnt; wr_en && !full && !(rd_en && !empty) |=> wr_count == $past(wr_count) + 4'h1; endproperty
	a_cnt: assert property (p_cnt) else $error("count off");
	property p_hset; wr_count >= high_level_set_threshold_in |-> fill_level_high_flag; endproperty
	a_hset: assert property (p_hset) else $error("high flag low");
	property p_hclr; wr_count < high_level_clear_threshold_in |-> !fill_level_high_flag; endproperty
	a_hclr: assert property (p_hclr) else $error("high flag high");
	c_ovf: cover property (overflow);
	c_udf: cover property (underflow);
	c_hi: cover property ($rose(fill_level_high_flag));
endmodule
bind fhf_top fhf_props i_fhf_props (.clk_sys, .rst_b, .wr_en, .rd_en, .full, .empty, .wr_ack, .rd_valid,
	.overflow, .underflow, .rd_data, .wr_count, .fill_level_high_flag, .high_level_set_threshold_in,
	.high_level_clear_threshold_in);
`default_nettype wire

// file: tb/fhf_user.sv
// writer and reader user logic
`default_nettype none
module fhf_user (
	output var logic wr_en = 1'b0,
	output var logic [7:0] wr_data = 8'h00,
	output var logic rd_en = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle data line toggles, never holds the old word
	task automatic req(bit w, logic [7:0] d, bit r);
		wr_en <= w;
		wr_data <= w ? d : ~wr_data;
		rd_en <= r;
	endtask
endmodule
`default_nettype wire

// file: tb/fhf_top_bench.sv
// flag queue bench
`default_nettype none
module fhf_top_bench import fhf_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic wr_en, rd_en, full, empty, wr_ack, rd_valid, overflow, underflow, hi, lo;
	logic [7:0] wr_data, rd_data, e_dat;
	logic [3:0] wr_count;
	logic [3:0] t_set = 4'h6; // set above clear, fixed from reset on
	logic [3:0] t_clr = 4'h4;
	logic [3:0] e_fl = 4'h0;
	logic [7:0] q[$];
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	int cnt = 0;
	bit m_hi;
	bit m_lo = 1'b1;
	always #4 clk_sys = ~clk_sys;
	fhf_user i_fhf_user (.wr_en, .wr_data, .rd_en);
	fhf_top i_fhf_top (.clk_sys, .rst_b, .wr_en, .wr_data, .rd_en, .rd_data, .full, .empty, .wr_ack,
		.rd_valid, .overflow, .underflow, .wr_count, .fill_level_high_flag(hi), .fill_level_low_flag(lo),
		.high_level_threshold_in(t_set), .high_level_set_threshold_in(t_set),
		.high_level_clear_threshold_in(t_clr));
	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic final_report;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// reset for 8 edges, thresholds loaded only while reset holds
	task automatic do_reset(logic [3:0] s, logic [3:0] c);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		t_set <= s;
		t_clr <= c;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		#1;
		chk("reset", {wr_ack, rd_valid, overflow, underflow, hi, lo, empty, full}, 8'h06);
		chk("reset data", rd_data, 8'h00);
		cnt = 0;
		e_fl = 4'h0;
		m_hi = 1'b0;
		m_lo = 1'b1;
		q.delete();
	endtask
	// issue one request, check answers to the previous one
	task automatic step(bit w, logic [7:0] d, bit r);
		@(posedge clk_sys);
		i_fhf_user.req(w, d, r);
		#1;
		m_hi = cnt >= t_set || (m_hi && cnt >= t_clr);
		m_lo = cnt <= FHF_LO_SET_CONST || (m_lo && cnt <= FHF_LO_CLR_CONST);
		chk("flags", {wr_ack, overflow, rd_valid, underflow}, e_fl);
		if (e_fl[1])
			chk("rd_data", rd_data, e_dat);
		chk("count", {empty, full, wr_count}, {cnt == 0, cnt == 8, 4'(cnt)});
		chk("high", hi, m_hi);
		chk("low", lo, m_lo);
		e_fl = {w && cnt < 8, w && cnt == 8, r && cnt > 0, r && cnt == 0};
		if (e_fl[1])
			e_dat = q.pop_front();
		if (e_fl[3])
			q.push_back(d);
		cnt = cnt + e_fl[3] - e_fl[1];
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 500) begin
			n_fail++;
			final_report;
		end
	end
	initial begin
		do_reset(4'h6, 4'h4);
		for (int i = 0; i < 10; i++)
			step(1'b1, 8'(8'h10 + i), i == 0); // read on empty, then overflow
		step(1'b1, 8'h5a, 1'b1); // full: write refused, read taken
		$display("test fill done");
		repeat (10)
			step(1'b0, 8'h00, 1'b1);
		step(1'b0, 8'h00, 1'b0);
		$display("test drain done");
		do_reset(4'h5, 4'h3); // new thresholds taken in a mid-run reset
		for (int i = 0; i < 7; i++)
			step(1'b1, 8'(8'ha0 + i), i > 4); // fill to the threshold, then both sides at once
		repeat (7)
			step(1'b0, 8'h00, 1'b1);
		step(1'b0, 8'h00, 1'b0);
		$display("test rethreshold done");
		final_report;
	end
endmodule
`default_nettype wire
